// [spims_top.sv]
// SPI master status, interrupt and queue bookkeeping with APB registers
//
// Operation
// [RULE1] Transmit status holds five flags
// [RULE2] Transmit mask gates flags onto transmit interrupt
// [RULE3] Receive status holds three flags
// [RULE4] Receive mask gates flags onto receive interrupt
// [RULE5] Transmit status read clears sticky flags
// [RULE6] Receive status read clears sticky flags
// [RULE7] Separate enables force interrupt outputs low
// [RULE8] Stop halts bit clock and interrupts
// [RULE9] Words sent strictly in write order
// [RULE10] Empty receive read undefined; check first
// [RULE11] Transmit queue four words, empty/space/full
// [RULE12] Data path eight or sixteen bits
// [RULE13] Overrun flagged, word dropped when full
// [RULE14] Word complete each word; done when drained
`timescale 1ns/1ns
module spims_top
  import spims_pkg::*;
#(
  parameter int unsigned TX_DEPTH = 4,
  parameter int unsigned RX_DEPTH = 4,
  parameter int unsigned HALF_CYC = HALF_BIT_CYC
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output      logic [31:0] PRDATA,
  output      logic        PREADY,
  output      logic        PSLVERR,
  input  wire logic        MISO,
  output      logic        SCLK,
  output      logic        MOSI,
  output      logic        SS_N,
  output      logic        TX_IRQ,
  output      logic        RX_IRQ
);
  localparam int unsigned TCW = $clog2(TX_DEPTH+1);
  localparam int unsigned RCW = $clog2(RX_DEPTH+1);

  // ********************************
  // State
  // ********************************
  typedef struct packed {
    spims_ctrl_t           ctrl;
    logic [TX_STS_W-1:0]   tx_sts;
    logic [RX_STS_W-1:0]   rx_sts;
    logic [TX_STS_W-1:0]   tx_mask;
    logic [RX_STS_W-1:0]   rx_mask;
    logic [31:0]           rdata;
    logic                  err;
    logic                  miso_meta;
    logic                  miso_sync;
  } spims_top_st_t;

  spims_top_st_t st_reg;
  spims_top_st_t st_next;

  logic              setup;
  logic              access;
  logic              wr;
  logic              rd;
  logic              mapped;
  logic              tx_push;
  logic              tx_pop;
  logic              rx_pop;
  logic [15:0]       tx_head;
  logic [15:0]       rx_head;
  logic [TCW-1:0]    tx_cnt;
  logic [RCW-1:0]    rx_cnt;
  logic              word_done;
  logic [15:0]       rx_word;
  logic              eng_idle;
  logic              rx_push;
  logic              tx_empty;
  logic              tx_full;
  logic              rx_full;
  logic [TX_STS_W-1:0] tx_set;
  logic [RX_STS_W-1:0] rx_set;
  spims_pins_t       pins;

  // ********************************
  // Queues
  // ********************************
  // [RULE11] Four word transmit queue
  spims_fifo #(
    .W     (16),
    .DEPTH (TX_DEPTH)
  ) u_txq (
    .clk   (CLK),
    .rst   (RST),
    .push  (tx_push),
    .wdata (PWDATA[15:0]),
    .pop   (tx_pop),
    .head  (tx_head),
    .count (tx_cnt)
  );

  spims_fifo #(
    .W     (16),
    .DEPTH (RX_DEPTH)
  ) u_rxq (
    .clk   (CLK),
    .rst   (RST),
    .push  (rx_push),
    .wdata (rx_word),
    .pop   (rx_pop),
    .head  (rx_head),
    .count (rx_cnt)
  );

  spims_engine #(
    .HALF_CYC (HALF_CYC)
  ) u_eng (
    .clk       (CLK),
    .rst       (RST),
    .run       (st_reg.ctrl.run),
    .wide      (st_reg.ctrl.wide),
    .have_word (!tx_empty),
    .tx_word   (tx_head),
    .miso_s    (st_reg.miso_sync),
    .tx_pop    (tx_pop),
    .word_done (word_done),
    .rx_word   (rx_word),
    .idle      (eng_idle),
    .pins      (pins)
  );

  assign tx_empty = (tx_cnt == '0);
  assign tx_full  = (tx_cnt == TCW'(TX_DEPTH));
  assign rx_full  = (rx_cnt == RCW'(RX_DEPTH));

  // ********************************
  // Bus decode
  // ********************************
  assign setup  = PSEL && !PENABLE;
  assign access = PSEL && PENABLE;
  assign wr     = access && PWRITE && !st_reg.err;
  assign rd     = access && !PWRITE && !st_reg.err;
  assign PREADY = 1'b1;
  assign PSLVERR = access && st_reg.err;
  assign PRDATA = st_reg.rdata;

  always_comb begin
    case (PADDR)
      OFS_CTRL, OFS_TX_STS, OFS_RX_STS, OFS_TX_MASK,
      OFS_RX_MASK, OFS_TX_DATA, OFS_RX_DATA: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Refused write on a full queue drops the word
  assign tx_push = wr && (PADDR == OFS_TX_DATA) && !tx_full;
  // [RULE10] Empty read pops nothing
  assign rx_pop  = rd && (PADDR == OFS_RX_DATA);
  // [RULE13] Drop word when full
  assign rx_push = word_done && !rx_full;

  // Status sources
  always_comb begin
    tx_set = '0;
    rx_set = '0;
    // [RULE1] Transmit flag sources
    tx_set[TX_EMPTY_BIT]    = tx_empty;
    tx_set[TX_SPACE_BIT]    = !tx_full;
    tx_set[TX_IDLE_BIT]     = eng_idle;
    tx_set[TX_COMPLETE_BIT] = word_done;
    // [RULE14] Done when queue drained
    tx_set[TX_DONE_BIT]     = word_done && tx_empty;
    // [RULE3] Receive flag sources
    rx_set[RX_FULL_BIT]     = rx_full;
    rx_set[RX_DATA_BIT]     = (rx_cnt != '0);
    // [RULE13] Overrun on full queue
    rx_set[RX_OVER_BIT]     = word_done && rx_full;
  end

  // ********************************
  // Next state
  // ********************************
  always_comb begin
    st_next           = st_reg;
    st_next.miso_meta = MISO;
    st_next.miso_sync = st_reg.miso_meta;
    if (setup) begin
      st_next.err   = !mapped ||
                      (PWRITE && (PADDR == OFS_TX_DATA) && tx_full);
      st_next.rdata = '0;
      case (PADDR)
        OFS_CTRL: begin
          st_next.rdata[CTRL_RUN_BIT]   = st_reg.ctrl.run;
          st_next.rdata[CTRL_TXIEN_BIT] = st_reg.ctrl.tx_irq_en;
          st_next.rdata[CTRL_RXIEN_BIT] = st_reg.ctrl.rx_irq_en;
          st_next.rdata[CTRL_WIDE_BIT]  = st_reg.ctrl.wide;
        end
        OFS_TX_STS:  st_next.rdata[TX_STS_W-1:0] = st_reg.tx_sts;
        OFS_RX_STS:  st_next.rdata[RX_STS_W-1:0] = st_reg.rx_sts;
        OFS_TX_MASK: st_next.rdata[TX_STS_W-1:0] = st_reg.tx_mask;
        OFS_RX_MASK: st_next.rdata[RX_STS_W-1:0] = st_reg.rx_mask;
        OFS_RX_DATA: st_next.rdata[15:0] = rx_head;
        default:     st_next.rdata = '0;
      endcase
    end
    if (wr) begin
      case (PADDR)
        OFS_CTRL: begin
          // [RULE8] Run bit stops engine
          st_next.ctrl.run       = PWDATA[CTRL_RUN_BIT];
          // [RULE7] Per direction enables
          st_next.ctrl.tx_irq_en = PWDATA[CTRL_TXIEN_BIT];
          st_next.ctrl.rx_irq_en = PWDATA[CTRL_RXIEN_BIT];
          st_next.ctrl.wide      = PWDATA[CTRL_WIDE_BIT];
        end
        OFS_TX_MASK: st_next.tx_mask = PWDATA[TX_STS_W-1:0];
        OFS_RX_MASK: st_next.rx_mask = PWDATA[RX_STS_W-1:0];
        default: ;
      endcase
    end
    // [RULE5] Read or data write clears
    if ((rd && (PADDR == OFS_TX_STS)) || (wr && (PADDR == OFS_TX_DATA))) begin
      st_next.tx_sts = '0;
    end
    // [RULE6] Read clears receive flags
    if (rd && (PADDR == OFS_RX_STS)) begin
      st_next.rx_sts = '0;
    end
    // Set wins over a same-cycle clear
    st_next.tx_sts = st_next.tx_sts | tx_set;
    st_next.rx_sts = st_next.rx_sts | rx_set;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_reg         <= '0;
      st_reg.ctrl    <= spims_ctrl_t'(CTRL_RST);
      st_reg.tx_sts  <= TX_STS_RST;
      st_reg.rx_sts  <= RX_STS_RST;
      st_reg.tx_mask <= TX_MASK_RST;
      st_reg.rx_mask <= RX_MASK_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ********************************
  // Outputs
  // ********************************
  // [RULE2] Masked transmit interrupt
  // [RULE7] Enable and run gate it
  assign TX_IRQ = st_reg.ctrl.run && st_reg.ctrl.tx_irq_en &&
                  |(st_reg.tx_sts & st_reg.tx_mask);
  // [RULE4] Masked receive interrupt
  // [RULE8] Stop silences interrupts
  assign RX_IRQ = st_reg.ctrl.run && st_reg.ctrl.rx_irq_en &&
                  |(st_reg.rx_sts & st_reg.rx_mask);

  assign SCLK = pins.sclk;
  assign MOSI = pins.mosi;
  assign SS_N = pins.ss_n;
endmodule

// [spims_pkg.sv]
// Shared constants and types for the SPI master status and interrupt block
package spims_pkg;

  // ********************************
  // Timing
  // ********************************
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned HALF_BIT_NS   = 500;
  // Least time rounds up, never below one cycle
  localparam int unsigned HALF_BIT_CYC  =
    ((HALF_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
    ((HALF_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ********************************
  // Register map
  // ********************************
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_TX_STS  = 8'h04;
  localparam logic [7:0] OFS_RX_STS  = 8'h08;
  localparam logic [7:0] OFS_TX_MASK = 8'h0c;
  localparam logic [7:0] OFS_RX_MASK = 8'h10;
  localparam logic [7:0] OFS_TX_DATA = 8'h14;
  localparam logic [7:0] OFS_RX_DATA = 8'h18;

  // Control fields
  localparam int unsigned CTRL_RUN_BIT   = 0;
  localparam int unsigned CTRL_TXIEN_BIT = 1;
  localparam int unsigned CTRL_RXIEN_BIT = 2;
  localparam int unsigned CTRL_WIDE_BIT  = 3;
  localparam logic [3:0]  CTRL_RST       = 4'h0;

  // Transmit status fields
  localparam int unsigned TX_DONE_BIT     = 0;
  localparam int unsigned TX_EMPTY_BIT    = 1;
  localparam int unsigned TX_SPACE_BIT    = 2;
  localparam int unsigned TX_COMPLETE_BIT = 3;
  localparam int unsigned TX_IDLE_BIT     = 4;
  localparam int unsigned TX_STS_W        = 5;

  // Receive status fields
  localparam int unsigned RX_FULL_BIT = 0;
  localparam int unsigned RX_DATA_BIT = 1;
  localparam int unsigned RX_OVER_BIT = 2;
  localparam int unsigned RX_STS_W    = 3;

  localparam logic [4:0] TX_STS_RST  = 5'h00;
  localparam logic [2:0] RX_STS_RST  = 3'h0;
  localparam logic [4:0] TX_MASK_RST = 5'h00;
  localparam logic [2:0] RX_MASK_RST = 3'h0;

  // ********************************
  // Types
  // ********************************
  typedef struct packed {
    logic sclk;
    logic mosi;
    logic ss_n;
  } spims_pins_t;

  typedef struct packed {
    logic        run;
    logic        tx_irq_en;
    logic        rx_irq_en;
    logic        wide;
  } spims_ctrl_t;

endpackage

// [spims_fifo.sv]
// Small queue memory with registered head word
`timescale 1ns/1ns
module spims_fifo
  import spims_pkg::*;
#(
  parameter int unsigned W     = 16,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       push,
  input  wire logic [W-1:0]               wdata,
  input  wire logic                       pop,
  output      logic [W-1:0]               head,
  output      logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wp;
    logic [PW-1:0]           rp;
    logic [CW-1:0]           cnt;
    logic [W-1:0]            head;
  } spims_fifo_st_t;

  spims_fifo_st_t st_reg;
  spims_fifo_st_t st_next;

  logic do_push;
  logic do_pop;

  // ********************************
  // Next state
  // ********************************
  always_comb begin
    st_next = st_reg;
    // Refused pushes and pops leave the queue untouched
    do_push = push && (st_reg.cnt != CW'(DEPTH));
    do_pop  = pop && (st_reg.cnt != '0);
    if (do_push) begin
      st_next.mem[st_reg.wp] = wdata;
      st_next.wp = (st_reg.wp == PW'(DEPTH-1)) ? '0 : st_reg.wp + 1'b1;
    end
    if (do_pop) begin
      st_next.rp = (st_reg.rp == PW'(DEPTH-1)) ? '0 : st_reg.rp + 1'b1;
    end
    if (do_push && !do_pop) begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end else if (do_pop && !do_push) begin
      st_next.cnt = st_reg.cnt - 1'b1;
    end
    // Head tracks the next read slot so readers see it from a flop
    st_next.head = st_next.mem[st_next.rp];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign head  = st_reg.head;
  assign count = st_reg.cnt;
endmodule

// [spims_engine.sv]
// Serial shifter: mode 0, MSB first, 8 or 16 bit words
`timescale 1ns/1ns
module spims_engine
  import spims_pkg::*;
#(
  parameter int unsigned HALF_CYC = HALF_BIT_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        run,
  input  wire logic        wide,
  input  wire logic        have_word,
  input  wire logic [15:0] tx_word,
  input  wire logic        miso_s,
  output      logic        tx_pop,
  output      logic        word_done,
  output      logic [15:0] rx_word,
  output      logic        idle,
  output      spims_pins_t pins
);
  localparam int unsigned DW = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;

  typedef enum logic {S_IDLE, S_SHIFT} spims_eng_state_t;

  typedef struct packed {
    spims_eng_state_t state;
    logic [DW-1:0]    div;
    logic [3:0]       bits;
    logic [15:0]      tx_sh;
    logic [15:0]      rx_sh;
    logic             sclk;
    logic             ss_n;
    logic             done;
  } spims_eng_st_t;

  spims_eng_st_t st_reg;
  spims_eng_st_t st_next;

  logic tick;

  always_comb begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    tx_pop       = 1'b0;
    // Bit-rate divider stalls while stopped
    tick = run && (st_reg.div == DW'(HALF_CYC-1));
    if (run) begin
      st_next.div = tick ? '0 : st_reg.div + 1'b1;
    end
    case (st_reg.state)
      S_IDLE: begin
        st_next.ss_n = 1'b1;
        // [RULE9] Strict queue order
        if (run && have_word) begin
          tx_pop        = 1'b1;
          st_next.tx_sh = wide ? tx_word : {tx_word[7:0], 8'h00};
          st_next.bits  = wide ? 4'hf : 4'h7;
          st_next.div   = '0;
          st_next.ss_n  = 1'b0;
          st_next.state = S_SHIFT;
        end
      end
      S_SHIFT: begin
        if (tick && !st_reg.sclk) begin
          st_next.sclk  = 1'b1;
          st_next.rx_sh = {st_reg.rx_sh[14:0], miso_s};
        end else if (tick) begin
          st_next.sclk = 1'b0;
          if (st_reg.bits == 4'h0) begin
            // [RULE14] Word end pulse
            st_next.done  = 1'b1;
            st_next.ss_n  = 1'b1;
            st_next.state = S_IDLE;
          end else begin
            st_next.tx_sh = {st_reg.tx_sh[14:0], 1'b0};
            st_next.bits  = st_reg.bits - 1'b1;
          end
        end
      end
      default: begin
        st_next.state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg       <= '0;
      st_reg.ss_n  <= 1'b1;
      st_reg.state <= S_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // [RULE12] Word width follows mode
  assign rx_word   = wide ? st_reg.rx_sh : {8'h00, st_reg.rx_sh[7:0]};
  assign word_done = st_reg.done;
  assign idle      = (st_reg.state == S_IDLE);
  assign pins.sclk = st_reg.sclk;
  assign pins.mosi = st_reg.tx_sh[15];
  assign pins.ss_n = st_reg.ss_n;
endmodule

// [spims_slave.sv]
// Behavioural SPI slave, mode 0, MSB first, on the far side of the block
`timescale 1ns/1ns
module spims_slave (
  input  wire logic        sclk,
  input  wire logic        mosi,
  input  wire logic        ss_n,
  input  wire logic        wide,
  input  wire logic [15:0] reply,
  output      logic        miso,
  output      logic [15:0] got,
  output      logic [7:0]  seen
);
  logic [15:0] sh_out;
  logic [15:0] sh_in;
  int          n;
  initial begin
    miso = 1'b0;
    got  = 16'h0;
    seen = 8'h0;
    n    = 0;
  end
  // Reply changes per frame so that order mistakes show
  always @(negedge ss_n) begin
    sh_out = reply ^ {seen, seen};
    if (!wide) sh_out = {sh_out[7:0], 8'h00};
    sh_in = 16'h0;
    n     = 0;
    miso  = sh_out[15];
  end
  always @(posedge sclk) if (!ss_n) begin
    sh_in = {sh_in[14:0], mosi};
    n     = n + 1;
  end
  always @(negedge sclk) if (!ss_n) begin
    sh_out = sh_out << 1;
    miso   = sh_out[15];
  end
  // Released line is not held: show the inverse so stale bits never pass
  always @(posedge ss_n) if (n > 0) begin
    got  = sh_in;
    seen = seen + 8'h1;
    miso = ~miso;
  end
endmodule

// [spims_top_sva.sv]
// Port checker for the SPI master status block
`timescale 1ns/1ns
module spims_top_sva
  import spims_pkg::*;
(
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        MISO,
  input wire logic        SCLK,
  input wire logic        MOSI,
  input wire logic        SS_N,
  input wire logic        TX_IRQ,
  input wire logic        RX_IRQ
);
  // ********************************
  // Shadow of control, masks, bit count
  // ********************************
  logic [3:0] ctrl_q;
  logic [4:0] txm_q;
  logic [2:0] rxm_q;
  logic [4:0] bits_q;
  logic       sclk_q;
  logic       wr_ok;
  assign wr_ok = PSEL && PENABLE && PWRITE && PREADY;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_q <= 4'h0;
      txm_q  <= 5'h00;
      rxm_q  <= 3'h0;
      bits_q <= 5'h00;
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= SCLK;
      if (SS_N) bits_q <= 5'h00;
      else if (SCLK && !sclk_q) bits_q <= bits_q + 5'h01;
      if (wr_ok && PADDR == OFS_CTRL) ctrl_q <= PWDATA[3:0];
      if (wr_ok && PADDR == OFS_TX_MASK) txm_q <= PWDATA[4:0];
      if (wr_ok && PADDR == OFS_RX_MASK) rxm_q <= PWDATA[2:0];
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_stop;
    wr_ok && PADDR == OFS_CTRL && !PWDATA[CTRL_RUN_BIT];
  endsequence
  sequence s_frozen;
    ##1 $stable(SCLK) [*2];
  endsequence
  a_tx_irq_gate: assert property (
    !(ctrl_q[CTRL_RUN_BIT] && ctrl_q[CTRL_TXIEN_BIT]) |-> !TX_IRQ) else $error("tx irq not gated");
  a_rx_irq_gate: assert property (
    !(ctrl_q[CTRL_RUN_BIT] && ctrl_q[CTRL_RXIEN_BIT]) |-> !RX_IRQ) else $error("rx irq not gated");
  a_tx_mask_off: assert property (
    txm_q == 5'h00 |-> !TX_IRQ) else $error("tx irq with empty mask");
  a_rx_mask_off: assert property (
    rxm_q == 3'h0 |-> !RX_IRQ) else $error("rx irq with empty mask");
  a_stop_freeze: assert property (
    s_stop |=> s_frozen) else $error("serial clock runs while stopped");
  a_frame_bits: assert property (
    $rose(SS_N) |-> bits_q == (ctrl_q[CTRL_WIDE_BIT] ? 5'h10 : 5'h08)) else $error("bad word size");
  a_mosi_hold: assert property (
    $rose(SCLK) |-> $stable(MOSI)) else $error("data moved at sampling edge");
  a_sclk_idle: assert property (
    SS_N |-> !SCLK) else $error("serial clock outside frame");
endmodule

bind spims_top spims_top_sva u_sva (
  .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .MISO(MISO), .SCLK(SCLK), .MOSI(MOSI), .SS_N(SS_N),
  .TX_IRQ(TX_IRQ), .RX_IRQ(RX_IRQ)
);

// [spims_top_test.sv]
// Self-checking bench for the SPI master status and interrupt block
`timescale 1ns/1ns
module spims_top_test
  import spims_pkg::*;
();
  typedef struct packed {
    logic [31:0] d;
    logic [31:0] m;
    logic        e;
  } spims_exp_t;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr;
  logic        miso, sclk, mosi, ss_n, tx_irq, rx_irq, wide, s;
  logic [7:0]  paddr, seen;
  logic [15:0] reply, got;
  logic [31:0] pwdata, prdata, seed;
  logic [31:0] txw [5];
  spims_exp_t  exp_q [$];
  logic [15:0] ser_q [$];
  int          failures, compares, i, k;
  // Half period 4 cycles gives the 800 ns link clock
  spims_top #(.HALF_CYC(4)) dut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .MISO(miso), .SCLK(sclk), .MOSI(mosi), .SS_N(ss_n),
    .TX_IRQ(tx_irq), .RX_IRQ(rx_irq));
  spims_slave slave (.sclk(sclk), .mosi(mosi), .ss_n(ss_n), .wide(wide), .reply(reply),
    .miso(miso), .got(got), .seen(seen));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ********************************
  // Helpers
  // ********************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] rx_exp(input int f);
    logic [15:0] r;
    r = reply ^ {f[7:0], f[7:0]};
    return wide ? {16'h0, r} : {24'h0, r[7:0]};
  endfunction
  task automatic print_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] gv, input logic [31:0] ev, input logic [31:0] m);
    compares++;
    if (((gv ^ ev) & m) !== 32'h0) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, gv, ev);
    end
  endtask
  task automatic timeout();
    failures++;
    $display("ERROR %0t: wait timed out", $time);
    print_verdict();
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [31:0] x, input logic [31:0] m, input logic e);
    int n;
    exp_q.push_back('{x, m, e});
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) timeout();
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, 32'h0, 32'h0, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
    apb(a, 1'b0, 32'h0, x, m, 1'b0);
  endtask
  task automatic irq_is(input logic t, input logic r);
    @(negedge clk);
    chk({31'h0, tx_irq}, {31'h0, t}, 32'h1);
    chk({31'h0, rx_irq}, {31'h0, r}, 32'h1);
  endtask
  task automatic wait_seen(input int n);
    int c;
    c = 0;
    while (seen < n && c < 5000) begin
      @(posedge clk);
      c++;
    end
    if (c >= 5000) timeout();
    repeat (3) @(posedge clk);
  endtask
  // ********************************
  // Result watchers
  // ********************************
  always @(posedge clk) if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
    if (exp_q.size() == 0) timeout();
    else begin
      chk(prdata, exp_q[0].d, exp_q[0].m);
      chk({31'h0, pslverr}, {31'h0, exp_q[0].e}, 32'h1);
      void'(exp_q.pop_front());
    end
  end
  always @(seen) if (seen !== 8'h00) begin
    if (ser_q.size() == 0) timeout();
    else chk({16'h0, got}, {16'h0, ser_q.pop_front()}, 32'hFFFF);
  end
  // ********************************
  // Main sequence
  // ********************************
  initial begin
    rst     = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h0;
    pwdata  = 32'h0;
    wide    = 1'b0;
    seed    = 32'h0001_2546;
    reply   = 16'(rnd());
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(OFS_CTRL, 32'h0, 32'hF);
    rd(OFS_TX_MASK, 32'h0, 32'h1F);
    rd(OFS_RX_MASK, 32'h0, 32'h7);
    rd(OFS_TX_STS, 32'h16, 32'h1F);
    rd(OFS_RX_STS, 32'h0, 32'h7);
    apb(8'h1C, 1'b0, 32'h0, 32'h0, 32'hFFFF_FFFF, 1'b1);
    $display("test reset values done");
    wr(OFS_TX_MASK, 32'h10);
    wr(OFS_CTRL, 32'h2);
    for (i = 0; i < 4; i++) begin
      txw[i] = rnd();
      ser_q.push_back({8'h00, txw[i][7:0]});
      wr(OFS_TX_DATA, txw[i]);
    end
    apb(OFS_TX_DATA, 1'b1, rnd(), 32'h0, 32'h0, 1'b1);
    irq_is(1'b0, 1'b0);
    rd(OFS_TX_STS, 32'h10, 32'h11);
    rd(OFS_TX_STS, 32'h10, 32'h1F);
    $display("test queue fill done");
    wr(OFS_TX_MASK, 32'h1);
    wr(OFS_CTRL, 32'h7);
    wait_seen(4);
    irq_is(1'b1, 1'b0);
    rd(OFS_TX_STS, 32'h1F, 32'h1F);
    irq_is(1'b0, 1'b0);
    wr(OFS_TX_MASK, 32'h2);
    irq_is(1'b1, 1'b0);
    wr(OFS_CTRL, 32'h5);
    irq_is(1'b0, 1'b0);
    wr(OFS_RX_MASK, 32'h2);
    irq_is(1'b0, 1'b1);
    rd(OFS_RX_STS, 32'h3, 32'h7);
    for (i = 0; i < 4; i++) rd(OFS_RX_DATA, rx_exp(i), 32'hFFFF);
    rd(OFS_RX_STS, 32'h0, 32'h4);
    rd(OFS_RX_STS, 32'h0, 32'h7);
    irq_is(1'b0, 1'b0);
    $display("test narrow transfer done");
    wide <= 1'b1;
    wr(OFS_CTRL, 32'hD);
    for (i = 0; i < 5; i++) begin
      txw[i] = rnd();
      ser_q.push_back(txw[i][15:0]);
      wr(OFS_TX_DATA, txw[i]);
      k = 0;
      while (ss_n !== 1'b0 && k < 100) begin
        @(posedge clk);
        k++;
      end
      if (k >= 100) timeout();
    end
    wr(OFS_CTRL, 32'hC);
    @(negedge clk);
    s = sclk;
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk({31'h0, sclk}, {31'h0, s}, 32'h1);
    chk({31'h0, ss_n}, 32'h0, 32'h1);
    wr(OFS_CTRL, 32'hD);
    wait_seen(9);
    rd(OFS_RX_STS, 32'h7, 32'h7);
    rd(OFS_RX_STS, 32'h3, 32'h7);
    for (i = 0; i < 4; i++) rd(OFS_RX_DATA, rx_exp(i + 4), 32'hFFFF);
    $display("test wide overrun done");
    print_verdict();
  end
endmodule
